// *** emaa_consts.svh ***
// Timing counts and field positions shared by both ends of the master link.
`ifndef EMAA_CONSTS_SVH
`define EMAA_CONSTS_SVH
`define EMAA_CLK_MHZ 100
`define EMAA_BCLK_DIV 4
`define EMAA_RELEASE_BCLKS 64
`define EMAA_REARM_BCLKS 2
`define EMAA_ARB_DELAY_BCLKS 2
`define EMAA_UPPER_LSB 24
`define EMAA_UPPER_MSB 31
`define EMAA_LA_LSB 2
`define EMAA_CNT_W 8
`endif

// *** emaa_pkg.sv ***
// Types used by the master end of the link and by the bench; the board end uses none of them.
package emaa_pkg;
  typedef logic [31:2] emaa_addr_t;
  typedef logic [3:0] emaa_be_t;
  typedef enum logic [1:0] {
    EMAA_ST_IDLE,
    EMAA_ST_REQ,
    EMAA_ST_OWN,
    EMAA_ST_REARM
  } emaa_mst_e;
endpackage

// *** emaa_bus_if.sv ***
// Slot bus between the expansion master and the system board.
`timescale 1ns/100ps
interface emaa_bus_if;
  logic bclk;
  logic mreq_n;
  logic mak_n;
  logic [31:2] la_o;
  logic la_oe_n;
  logic [3:0] be_n;
  logic start_n;
  logic cmd_n;
  logic mio;
  logic wr;
  logic lock_n;
  logic irq;
  modport master (
    input bclk,
    input mak_n,
    input cmd_n,
    output mreq_n,
    output la_o,
    output la_oe_n,
    output be_n,
    output start_n,
    output mio,
    output wr,
    output lock_n,
    output irq
  );
  modport board (
    output bclk,
    output mak_n,
    output cmd_n,
    input mreq_n,
    input la_o,
    input la_oe_n,
    input be_n,
    input start_n,
    input mio,
    input wr,
    input lock_n,
    input irq
  );
endinterface

// *** emaa_sync.sv ***
// Two-flop synchroniser for levels that arrive from the other end.
`timescale 1ns/100ps
module emaa_sync (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic d,
  output logic q
);
  logic meta_r;
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      meta_r <= 1'h1;
      q <= 1'h1;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// *** emaa_master.sv ***
// Expansion bus master end: slot request, address drive, lock and interrupt.
// How it works
// - Receiver takes interrupt on rising edge
// - Level mode: receiver sees low level
// - Level mode re-raises if still low
// - Board signals interrupt with edge mode
// - Slaves latch pipelined address themselves
// - Address valid before START, held after
// - DMA/ISA: address one clock before command
// - Slave latches address at START or command
// - ISA slave latches upper lines on BALE
// - Lines 24 to 31 drive inverted
// - LOCK held for indivisible access
// - Drive bus on falling edge after grant
// - Board drops grant after request drops
// - Board drops grant to preempt master
// - Release within 64 clocks of preemption
// - Wait two clocks before re-requesting
`timescale 1ns/100ps
`include "emaa_consts.svh"
module emaa_master
  import emaa_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST_N,
  emaa_bus_if.master BUS,
  input wire logic XFER_REQ,
  input wire emaa_pkg::emaa_addr_t XFER_ADDR,
  input wire emaa_pkg::emaa_be_t XFER_BE,
  input wire logic XFER_MIO,
  input wire logic XFER_WR,
  input wire logic XFER_LOCK,
  input wire logic XFER_DONE,
  input wire logic IRQ_EVENT,
  input wire logic IRQ_SERVICED,
  output logic OWNER,
  output logic PREEMPTED,
  output logic IRQ_PENDING
);
  import emaa_pkg::*;

  logic bclk_s;
  logic bclk_n_s;
  logic mak_n_s;
  logic done_r;
  logic bclk_d_r;
  logic bclk_fall;
  logic bclk_rise;
  emaa_mst_e state_r;
  logic [`EMAA_CNT_W-1:0] cnt_r;
  logic mak_seen_r;
  logic drive_r;
  logic mreq_n_r;
  logic [31:2] la_r;
  logic [3:0] be_n_r;
  logic mio_r;
  logic wr_r;
  logic lock_n_r;
  logic irq_r;

  // Drive the upper address byte with inverted polarity.
  function automatic logic [31:2] la_encode(input logic [31:2] a);
    logic [31:2] r;
    r = a;
    r[`EMAA_UPPER_MSB:`EMAA_UPPER_LSB] = ~a[`EMAA_UPPER_MSB:`EMAA_UPPER_LSB];
    return r;
  endfunction

  // The bus clock idles low but the synchroniser resets high.
  // Carrying the inverse keeps a false bus clock edge from following reset.
  emaa_sync u_sync_bclk (
    .CLK_SYS(CLK_SYS),
    .RST_N(RST_N),
    .d(~BUS.bclk),
    .q(bclk_n_s)
  );
  assign bclk_s = ~bclk_n_s;
  emaa_sync u_sync_mak (
    .CLK_SYS(CLK_SYS),
    .RST_N(RST_N),
    .d(BUS.mak_n),
    .q(mak_n_s)
  );

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      bclk_d_r <= 1'h0;
    end else begin
      bclk_d_r <= bclk_s;
    end
  end
  assign bclk_fall = bclk_d_r & ~bclk_s;
  assign bclk_rise = ~bclk_d_r & bclk_s;

  // The done pulse may fall between bus clock edges, so it is held until the next rise.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      done_r <= 1'h0;
    end else if (XFER_DONE) begin
      done_r <= 1'h1;
    end else if (bclk_rise) begin
      done_r <= 1'h0;
    end
  end

  // Arbitration state; counts are in bus clocks, stepped on rising edges.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= EMAA_ST_IDLE;
      cnt_r <= 8'h00;
      mreq_n_r <= 1'h1;
      mak_seen_r <= 1'h0;
      PREEMPTED <= 1'h0;
    end else if (bclk_rise) begin
      case (state_r)
        EMAA_ST_IDLE: begin
          PREEMPTED <= 1'h0;
          if (XFER_REQ) begin
            mreq_n_r <= 1'h0;
            state_r <= EMAA_ST_REQ;
          end
        end
        EMAA_ST_REQ: begin
          if (!mak_n_s) begin
            mak_seen_r <= 1'h1;
            state_r <= EMAA_ST_OWN;
            cnt_r <= 8'h00;
          end
        end
        EMAA_ST_OWN: begin
          if (mak_n_s) begin
            PREEMPTED <= 1'h1;
            cnt_r <= cnt_r + 8'h01;
          end
          if (XFER_DONE || done_r || (mak_n_s && cnt_r >= 8'(`EMAA_RELEASE_BCLKS - 2))) begin
            mreq_n_r <= 1'h1;
            mak_seen_r <= 1'h0;
            cnt_r <= 8'h00;
            state_r <= EMAA_ST_REARM;
          end
        end
        EMAA_ST_REARM: begin
          if (cnt_r >= 8'(`EMAA_REARM_BCLKS - 1)) begin
            cnt_r <= 8'h00;
            state_r <= EMAA_ST_IDLE;
          end else begin
            cnt_r <= cnt_r + 8'h01;
          end
        end
        default: begin
          state_r <= EMAA_ST_IDLE;
          mreq_n_r <= 1'h1;
        end
      endcase
    end
  end

  // drive from the falling edge after grant
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      drive_r <= 1'h0;
    end else if (bclk_fall) begin
      drive_r <= mak_seen_r;
    end
  end

  // address set up before START and held
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      la_r <= 30'h00000000;
      be_n_r <= 4'hF;
      mio_r <= 1'h0;
      wr_r <= 1'h0;
    end else if (bclk_fall && mak_seen_r && !drive_r) begin
      // address stays put for the whole tenure
      la_r <= la_encode(XFER_ADDR);
      be_n_r <= ~XFER_BE;
      mio_r <= XFER_MIO;
      wr_r <= XFER_WR;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      lock_n_r <= 1'h1;
    end else if (bclk_fall) begin
      lock_n_r <= ~(mak_seen_r && XFER_LOCK);
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      irq_r <= 1'h0;
    end else if (IRQ_EVENT) begin
      irq_r <= 1'h1;
    end else if (IRQ_SERVICED) begin
      irq_r <= 1'h0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      OWNER <= 1'h0;
      IRQ_PENDING <= 1'h0;
    end else begin
      OWNER <= drive_r;
      IRQ_PENDING <= irq_r;
    end
  end

  assign BUS.mreq_n = mreq_n_r;
  assign BUS.la_o = la_r;
  assign BUS.la_oe_n = ~drive_r;
  assign BUS.be_n = be_n_r;
  assign BUS.start_n = 1'h1;
  assign BUS.mio = mio_r;
  assign BUS.wr = wr_r;
  assign BUS.lock_n = lock_n_r;
  assign BUS.irq = irq_r;
endmodule

// *** emaa_board.sv ***
// System board end: bus clock, slot grant with preemption, address capture, interrupt.
`timescale 1ns/100ps
`include "emaa_consts.svh"
module emaa_board
  import emaa_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST_N,
  emaa_bus_if.board BUS,
  input wire logic OTHER_REQ,
  input wire logic LEVEL_MODE,
  input wire logic EOI,
  output logic INT_TAKEN,
  output logic [31:2] CAPT_ADDR,
  output logic LOCKED
);
  import emaa_pkg::*;

  logic [1:0] div_r;
  logic bclk_r;
  logic mak_n_r;
  logic irq_d_r;
  logic [31:2] la_dec;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      div_r <= 2'h0;
      bclk_r <= 1'h0;
    end else begin
      div_r <= div_r + 2'h1;
      if (div_r == 2'(`EMAA_BCLK_DIV / 2 - 1)) begin
        bclk_r <= ~bclk_r;
        div_r <= 2'h0;
      end
    end
  end

  // grant on rising edge, withdraw on drop or preemption
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      mak_n_r <= 1'h1;
    end else if (!bclk_r && div_r == 2'(`EMAA_BCLK_DIV / 2 - 1)) begin
      mak_n_r <= BUS.mreq_n | OTHER_REQ;
    end
  end

  always_comb begin
    la_dec = BUS.la_o;
    la_dec[`EMAA_UPPER_MSB:`EMAA_UPPER_LSB] = ~BUS.la_o[`EMAA_UPPER_MSB:`EMAA_UPPER_LSB];
  end

  // capture address while the master drives
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      CAPT_ADDR <= 30'h00000000;
      LOCKED <= 1'h0;
    end else begin
      if (!BUS.la_oe_n) begin
        CAPT_ADDR <= la_dec;
      end
      LOCKED <= ~BUS.lock_n;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      irq_d_r <= 1'h0;
      INT_TAKEN <= 1'h0;
    end else begin
      irq_d_r <= BUS.irq;
      if (LEVEL_MODE) begin
        INT_TAKEN <= (~BUS.irq & irq_d_r) | (EOI & ~BUS.irq);
      end else begin
        INT_TAKEN <= BUS.irq & ~irq_d_r;
      end
    end
  end

  assign BUS.bclk = bclk_r;
  assign BUS.mak_n = mak_n_r;
  assign BUS.cmd_n = 1'h1;
endmodule

// *** emaa_chk.sv ***
// Assertion checker for the slot bus between the master and board ends.
`timescale 1ns/100ps
`include "emaa_consts.svh"
module emaa_chk (
  input logic CLK_SYS,
  input logic RST_N,
  input logic mreq_n,
  input logic mak_n,
  input logic [31:2] la_o,
  input logic la_oe_n,
  input logic [3:0] be_n,
  input logic mio,
  input logic wr,
  input logic lock_n
);
  // The slack covers the two-flop sync lag of the master on bclk and the grant.
  localparam int REL_MAX = `EMAA_RELEASE_BCLKS * `EMAA_BCLK_DIV + 12;
  logic gr_r;
  logic [9:0] wait_r;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N)
      gr_r <= 1'b0;
    else
      gr_r <= !mreq_n && (gr_r || !mak_n);
  end
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N)
      wait_r <= '0;
    else
      wait_r <= (gr_r && mak_n && !mreq_n) ? wait_r + 10'h001 : '0;
  end
  sequence s_rel;
    $rose(mreq_n) && !mak_n;
  endsequence
  property p_ack_req;
    $fell(mak_n) |-> !$past(mreq_n);
  endproperty
  a_ack_req: assert property (p_ack_req) else $error("grant without request");
  property p_ack_drop;
    s_rel |-> ##[1:12] mak_n;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("grant kept");
  property p_req_hold;
    !mreq_n && mak_n && !gr_r |=> !mreq_n;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped early");
  property p_release;
    wait_r < REL_MAX;
  endproperty
  a_release: assert property (p_release) else $error("bus not released");
  property p_float;
    $rose(mreq_n) |-> ##[0:8] la_oe_n;
  endproperty
  a_float: assert property (p_float) else $error("bus not floated");
  property p_rearm;
    $rose(mreq_n) |-> mreq_n[*8];
  endproperty
  a_rearm: assert property (p_rearm) else $error("request too soon");
  property p_addr_stable;
    !la_oe_n && !$past(la_oe_n) |-> $stable(la_o);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved");
  property p_status_stable;
    !la_oe_n && !$past(la_oe_n) |-> $stable({be_n, mio, wr});
  endproperty
  a_status_stable: assert property (p_status_stable) else $error("status moved");
  property p_drive_after_ack;
    $fell(la_oe_n) |-> !mak_n && !$past(mak_n, 4);
  endproperty
  a_drive_after_ack: assert property (p_drive_after_ack) else $error("drive before grant");
  property p_lock_owned;
    $fell(lock_n) |-> !mreq_n && !mak_n;
  endproperty
  a_lock_owned: assert property (p_lock_owned) else $error("lock without bus");
  property p_addr_lead;
    $fell(la_oe_n) |-> !la_oe_n[*4];
  endproperty
  a_addr_lead: assert property (p_addr_lead) else $error("address dropped too soon");
endmodule

// *** test_eisa_master_address_arbitration.sv ***
// Self-checking bench joining the master and board ends of the slot bus.
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("BAD t=%0t got %h exp %h", $time, a, b); end end
`define WAITF(c, n) for (int k = 0; k < n && (c) !== 1'b1; k++) #10;
module test_eisa_master_address_arbitration;
  import emaa_pkg::*;
  logic CLK_SYS = 0, RST_N = 0, XFER_REQ = 0, XFER_MIO = 0, XFER_WR = 0, XFER_LOCK = 0;
  logic XFER_DONE = 0, IRQ_EVENT = 0, IRQ_SERVICED = 0, OTHER_REQ = 0, LEVEL_MODE = 0, EOI = 0;
  emaa_addr_t XFER_ADDR = '0;
  emaa_be_t XFER_BE = '0;
  logic OWNER, PREEMPTED, IRQ_PENDING, INT_TAKEN, LOCKED;
  logic [31:2] CAPT_ADDR;
  int mismatches = 0, num_checks = 0, cyc = 0;
  emaa_bus_if emaa_bus_if_i ();
  emaa_master emaa_master_i (.CLK_SYS, .RST_N, .BUS(emaa_bus_if_i.master), .XFER_REQ,
    .XFER_ADDR, .XFER_BE, .XFER_MIO, .XFER_WR, .XFER_LOCK, .XFER_DONE, .IRQ_EVENT,
    .IRQ_SERVICED, .OWNER, .PREEMPTED, .IRQ_PENDING);
  emaa_board emaa_board_i (.CLK_SYS, .RST_N, .BUS(emaa_bus_if_i.board), .OTHER_REQ,
    .LEVEL_MODE, .EOI, .INT_TAKEN, .CAPT_ADDR, .LOCKED);
  emaa_chk emaa_chk_i (.CLK_SYS, .RST_N, .mreq_n(emaa_bus_if_i.mreq_n),
    .mak_n(emaa_bus_if_i.mak_n), .la_o(emaa_bus_if_i.la_o), .la_oe_n(emaa_bus_if_i.la_oe_n),
    .be_n(emaa_bus_if_i.be_n), .mio(emaa_bus_if_i.mio), .wr(emaa_bus_if_i.wr),
    .lock_n(emaa_bus_if_i.lock_n));
  initial begin
    forever #5 CLK_SYS = ~CLK_SYS;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // A hang in any handshake ends here rather than running forever.
  always @(posedge CLK_SYS) begin
    cyc++;
    if (cyc == 8000) begin
      mismatches++;
      final_report();
    end
  end
  task automatic xfer(input emaa_addr_t a, input emaa_be_t b, input logic l);
    XFER_ADDR = a;
    XFER_BE = b;
    XFER_MIO = a[2];
    XFER_WR = a[3];
    XFER_LOCK = l;
    XFER_REQ = 1;
    `WAITF(OWNER && !emaa_bus_if_i.la_oe_n, 200)
    XFER_REQ = 0;
    `CHK(emaa_bus_if_i.la_o, {~a[31:24], a[23:2]})
    `CHK({emaa_bus_if_i.be_n, emaa_bus_if_i.mio, emaa_bus_if_i.wr}, {~b, a[2], a[3]})
    `CHK(LOCKED, l)
    XFER_DONE = 1;
    #10 XFER_DONE = 0;
    `WAITF(emaa_bus_if_i.mak_n && emaa_bus_if_i.la_oe_n, 40)
    `CHK(CAPT_ADDR, a)
    `CHK(CAPT_ADDR[23:17], a[23:17])
    `CHK({emaa_bus_if_i.mak_n, emaa_bus_if_i.la_oe_n}, 2'b11)
  endtask
  // Back to back, so the second request lands in the rearm gap.
  task automatic sc_xfer();
    xfer(30'h3F00_0001, 4'hF, 1'b0);
    xfer(30'h00FF_FFFE, 4'h1, 1'b1);
  endtask
  task automatic sc_preempt();
    XFER_ADDR = 30'h0123_4567;
    XFER_REQ = 1;
    `WAITF(OWNER && !emaa_bus_if_i.la_oe_n, 200)
    XFER_REQ = 0;
    OTHER_REQ = 1;
    `WAITF(PREEMPTED, 40)
    `CHK(PREEMPTED, 1'b1)
    `WAITF(!OWNER && emaa_bus_if_i.mreq_n, 268)
    `CHK({OWNER, emaa_bus_if_i.mreq_n}, 2'b01)
    OTHER_REQ = 0;
    #200;
  endtask
  task automatic sc_irq();
    IRQ_EVENT = 1;
    #10 IRQ_EVENT = 0;
    `WAITF(INT_TAKEN, 12)
    `CHK(INT_TAKEN, 1'b1)
    `CHK({emaa_bus_if_i.irq, IRQ_PENDING}, 2'b11)
    #20 LEVEL_MODE = 1;
    IRQ_SERVICED = 1;
    #10 IRQ_SERVICED = 0;
    `WAITF(INT_TAKEN, 12)
    `CHK(INT_TAKEN, 1'b1)
    #20 EOI = 1;
    #10 EOI = 0;
    `WAITF(INT_TAKEN, 12)
    `CHK(INT_TAKEN, 1'b1)
    `CHK({emaa_bus_if_i.irq, IRQ_PENDING}, 2'b00)
  endtask
  initial begin
    repeat (20) @(posedge CLK_SYS);
    #1 RST_N = 1;
    #40;
    sc_xfer();
    sc_preempt();
    sc_irq();
    final_report();
  end
endmodule
